// >>> logic/swsm_map.svh
// Register offsets, field positions and reset values of the sleep/wake supply monitor.
`ifndef SWSM_MAP_SVH
`define SWSM_MAP_SVH
`define SWSM_OFS_CTRL      9'h1e3
`define SWSM_OFS_CMP       9'h1e4
`define SWSM_OFS_DUTY      9'h1eb
`define SWSM_POR_LSB       4
`define SWSM_LVD_LSB       0
`define SWSM_DUTY_LSB      6
`define SWSM_CTRL_MASK     8'h37
`define SWSM_DUTY_MASK     8'hc0
`define SWSM_RST_VAL       8'h00
`define SWSM_POR_NORESET   2'h3
`define SWSM_POR_RSVD      2'h2
`define SWSM_LVD_MAXCODE   3'h3
`define SWSM_SLOW_PER_NS   31250
`define SWSM_WAKE_MIN_US   75
`define SWSM_WAKE_MAX_US   105
`endif

// >>> logic/swsm_pkg.sv
// Types of the sleep/wake supply monitor.
package swsm_pkg;
    typedef enum logic [2:0] {
        SWSM_RUN,
        SWSM_HALT_REQ,
        SWSM_ASLEEP,
        SWSM_SYNCED,
        SWSM_POWERED,
        SWSM_SAMPLED
    } swsm_state_t;
    typedef logic [1:0] swsm_duty_t;
endpackage

// >>> logic/swsm_top.sv
// Sleep entry/exit sequencer and supply monitor control registers.
`timescale 1ns/1ps
`include "swsm_map.svh"
module swsm_top #(
    parameter int ADDR_W = 9
) (
    input  wire logic              sys_clk,
    input  wire logic              rstn,
    input  wire logic              clk_en,
    input  wire logic              slow_clk,
    input  wire logic              sleep_req,
    input  wire logic              irq_pending,
    input  wire logic              halt_acknowledge,
    input  wire logic              extended_io_bank_select,
    input  wire logic [ADDR_W-1:0] io_addr,
    input  wire logic              io_wr,
    input  wire logic              io_rd,
    input  wire logic [7:0]        io_wdata,
    input  wire logic              lvd_cmp_raw,
    input  wire logic              por_cmp_raw,
    output logic [7:0]             io_rdata,
    output logic                   halt_request,
    output logic                   power_down_strobe,
    output logic                   monitor_enable,
    output logic                   por_reset_req,
    output logic                   flash_enable,
    output swsm_pkg::swsm_duty_t   monitor_duty_ratio,
    output logic [1:0]             por_level_select,
    output logic [2:0]             lvd_trip_select,
    output logic                   supply_low_flag,
    output logic                   precise_supply_flag
);
    import swsm_pkg::*;

    // The three register offsets need nine address bits.
    if (ADDR_W < 9) begin : g_addr_check
        $error("swsm_top: ADDR_W must be at least 9");
    end

    // -------------------------------------------------------------------------
    // Register decode
    // -------------------------------------------------------------------------
    // Only the second bank reaches these registers.
    wire bank_ok  = extended_io_bank_select;
    wire sel_ctrl = bank_ok && (io_addr == ADDR_W'(`SWSM_OFS_CTRL));
    wire sel_cmp  = bank_ok && (io_addr == ADDR_W'(`SWSM_OFS_CMP));
    wire sel_duty = bank_ok && (io_addr == ADDR_W'(`SWSM_OFS_DUTY));

    logic [7:0] ctrl_q;
    logic [7:0] duty_q;
    logic [7:0] rdata_q;
    logic       lvd_q;
    logic       por_q;

    // Reserved bits are masked off on write, so they always read zero.
    wire [7:0] ctrl_d = io_wdata & `SWSM_CTRL_MASK;
    wire [7:0] duty_d = io_wdata & `SWSM_DUTY_MASK;
    wire [7:0] cmp_rd = {6'h00, lvd_q, por_q};
    wire [7:0] rd_d   = sel_ctrl ? ctrl_q : sel_cmp ? cmp_rd : sel_duty ? duty_q : 8'h00;

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            ctrl_q  <= `SWSM_RST_VAL;
            duty_q  <= `SWSM_RST_VAL;
            rdata_q <= 8'h00;
        end else if (clk_en) begin
            if (io_wr && sel_ctrl) ctrl_q <= ctrl_d;
            if (io_wr && sel_duty) duty_q <= duty_d;
            if (io_rd) rdata_q <= rd_d;
        end
    end

    assign io_rdata           = rdata_q;
    assign por_level_select   = ctrl_q[`SWSM_POR_LSB +: 2];
    assign lvd_trip_select    = ctrl_q[`SWSM_LVD_LSB +: 3];
    assign monitor_duty_ratio = duty_q[`SWSM_DUTY_LSB +: 2];

    // -------------------------------------------------------------------------
    // Slow clock edges and supply monitor duty
    // -------------------------------------------------------------------------
    logic       slow_q;
    logic [8:0] duty_cnt_q;
    wire        slow_rise = slow_clk && !slow_q;
    wire        slow_fall = !slow_clk && slow_q;
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            slow_q     <= 1'b0;
            duty_cnt_q <= 9'h000;
        end else if (clk_en) begin
            slow_q <= slow_clk;
            if (slow_rise) duty_cnt_q <= duty_cnt_q + 9'h001;
        end
    end

    // Running, the monitors stay on; asleep they are on one slow period per window.
    logic [8:0] duty_win;
    always_comb begin
        case (monitor_duty_ratio)
            2'h0:    duty_win = 9'h07f;
            2'h1:    duty_win = 9'h1ff;
            2'h2:    duty_win = 9'h01f;
            default: duty_win = 9'h007;
        endcase
    end
    assign monitor_enable = !power_down_strobe || ((duty_cnt_q & duty_win) == 9'h000);

    // -------------------------------------------------------------------------
    // Sleep sequencer
    // -------------------------------------------------------------------------
    swsm_state_t state_q;
    swsm_state_t state_d;
    always_comb begin
        state_d = state_q;
        case (state_q)
            SWSM_RUN:      if (sleep_req) state_d = SWSM_HALT_REQ;
            SWSM_HALT_REQ: if (halt_acknowledge) state_d = SWSM_ASLEEP;
            // Wake ignores the global enable; the mask is applied upstream.
            SWSM_ASLEEP:   if (irq_pending && slow_fall) state_d = SWSM_SYNCED;
            SWSM_SYNCED:   if (slow_rise) state_d = SWSM_POWERED;
            SWSM_POWERED:  if (slow_rise) state_d = SWSM_SAMPLED;
            SWSM_SAMPLED:  if (slow_fall) state_d = SWSM_RUN;
            default:       state_d = SWSM_RUN;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) state_q <= SWSM_RUN;
        else if (clk_en) state_q <= state_d;
    end

    // Halt request rises combinationally so the core sees it at once.
    assign halt_request = (state_q != SWSM_RUN) || sleep_req;
    // Strobe powers down flash, oscillator, filter and bandgap.
    assign power_down_strobe = (state_q == SWSM_ASLEEP) || (state_q == SWSM_SYNCED);

    // Comparators are frozen while asleep and resampled once powered again.
    wire cmp_load = (state_q == SWSM_RUN) || (state_q == SWSM_POWERED && slow_rise);
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            lvd_q <= 1'b0;
            por_q <= 1'b0;
        end else if (clk_en && cmp_load) begin
            lvd_q <= lvd_cmp_raw;
            por_q <= por_cmp_raw;
        end
    end
    assign supply_low_flag     = lvd_q;
    assign precise_supply_flag = por_q;
    // Level 11 still reports the comparator but never resets; 10 is reserved.
    assign por_reset_req = por_q && (por_level_select != `SWSM_POR_NORESET)
                           && (por_level_select != `SWSM_POR_RSVD);
    // Reserved trip codes leave the flash gate closed.
    assign flash_enable = !power_down_strobe && !lvd_q
                          && (lvd_trip_select <= `SWSM_LVD_MAXCODE);

    // -------------------------------------------------------------------------
    // Assertions
    // -------------------------------------------------------------------------
    property p_strobe_on_ack;
        @(posedge sys_clk) disable iff (!rstn)
        (state_q == SWSM_HALT_REQ && halt_acknowledge && clk_en) |=> power_down_strobe;
    endproperty
    a_strobe_on_ack: assert property (p_strobe_on_ack) else $error("strobe missing");

    property p_no_wake_without_irq;
        @(posedge sys_clk) disable iff (!rstn)
        (state_q == SWSM_ASLEEP && !irq_pending) |=> state_q == SWSM_ASLEEP;
    endproperty
    a_no_wake_without_irq: assert property (p_no_wake_without_irq) else $error("spurious wake");

    property p_sync_on_fall;
        @(posedge sys_clk) disable iff (!rstn)
        (state_q == SWSM_ASLEEP && $past(state_q) == SWSM_ASLEEP) ##1 state_q == SWSM_SYNCED
            |-> $past(slow_fall);
    endproperty
    a_sync_on_fall: assert property (p_sync_on_fall) else $error("sync not on fall");

    property p_release_on_rise;
        @(posedge sys_clk) disable iff (!rstn)
        $fell(power_down_strobe) |-> $past(slow_rise);
    endproperty
    a_release_on_rise: assert property (p_release_on_rise) else $error("strobe release edge");

    property p_halt_release_fall;
        @(posedge sys_clk) disable iff (!rstn)
        (state_q == SWSM_SAMPLED && slow_fall && clk_en && !sleep_req) |=> !halt_request;
    endproperty
    a_halt_release_fall: assert property (p_halt_release_fall) else $error("halt held");

    property p_strobe_implies_halt;
        @(posedge sys_clk) disable iff (!rstn)
        power_down_strobe |-> halt_request;
    endproperty
    a_strobe_implies_halt: assert property (p_strobe_implies_halt) else $error("strobe w/o halt");

    property p_cmp_read;
        @(posedge sys_clk) disable iff (!rstn)
        (io_rd && sel_cmp && clk_en) |=> io_rdata == {6'h00, $past(lvd_q), $past(por_q)};
    endproperty
    a_cmp_read: assert property (p_cmp_read) else $error("status read wrong");

    property p_bank_guard;
        @(posedge sys_clk) disable iff (!rstn)
        (io_wr && !extended_io_bank_select) |=> $stable(ctrl_q) && $stable(duty_q);
    endproperty
    a_bank_guard: assert property (p_bank_guard) else $error("write outside bank");

    property p_reserved_zero;
        @(posedge sys_clk) disable iff (!rstn)
        ((ctrl_q & ~`SWSM_CTRL_MASK) == 8'h00) && ((duty_q & ~`SWSM_DUTY_MASK) == 8'h00);
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");

    property p_level3_no_reset;
        @(posedge sys_clk) disable iff (!rstn)
        (por_level_select == `SWSM_POR_NORESET) |-> !por_reset_req;
    endproperty
    a_level3_no_reset: assert property (p_level3_no_reset) else $error("reset at level 3");

    property p_flags_frozen;
        @(posedge sys_clk) disable iff (!rstn)
        (state_q == SWSM_ASLEEP) |=> $stable(supply_low_flag) && $stable(precise_supply_flag);
    endproperty
    a_flags_frozen: assert property (p_flags_frozen) else $error("flags moved");

    property p_sample_loads;
        @(posedge sys_clk) disable iff (!rstn)
        (state_q == SWSM_POWERED && slow_rise && clk_en)
            |=> (supply_low_flag == $past(lvd_cmp_raw))
                && (precise_supply_flag == $past(por_cmp_raw));
    endproperty
    a_sample_loads: assert property (p_sample_loads) else $error("no sample");
endmodule

// >>> sim/swsm_cpu_model.sv
// Behavioural CPU core answering the halt request handshake.
`timescale 1ns/1ps
module swsm_cpu_model (
    input  wire logic sys_clk,
    input  wire logic rstn,
    input  wire logic halt_request,
    output logic      halt_acknowledge
);
    // The core looks at the request on every rising core clock edge, so the
    // acknowledge both rises and falls exactly one edge after the request.
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            halt_acknowledge <= 1'b0;
        end else begin
            halt_acknowledge <= halt_request;
        end
    end
endmodule

// >>> sim/tb_swsm_top.sv
// Self-checking bench of the sleep/wake supply monitor.
`timescale 1ns/1ps
`include "swsm_map.svh"
module tb_swsm_top;
    localparam int HALF = 1562;
    // One microsecond is a hundred core cycles.
    localparam int LAT_MIN = `SWSM_WAKE_MIN_US * 100;
    localparam int LAT_MAX = `SWSM_WAKE_MAX_US * 100;
    logic       sys_clk = 1'b0;
    logic       rstn = 1'b0;
    logic       clk_en = 1'b1;
    logic       slow_clk = 1'b0;
    logic       sleep_req = 1'b0;
    logic       irq_pending = 1'b0;
    logic       bank = 1'b0;
    logic [8:0] io_addr = 9'h000;
    logic       io_wr = 1'b0;
    logic       io_rd = 1'b0;
    logic [7:0] io_wdata = 8'h00;
    logic       lvd_raw = 1'b0;
    logic       por_raw = 1'b0;
    logic [7:0] io_rdata;
    logic       halt_request;
    logic       halt_acknowledge;
    logic       strobe;
    logic       por_req;
    logic       flash_en;
    logic [1:0] duty;
    logic [1:0] por_lvl;
    logic [2:0] trip;
    logic [7:0] rv;
    logic       mon_en;
    logic       low_flag;
    logic       prec_flag;
    logic [25:0] rows [6];
    int         err_count = 0;
    int         n_checks = 0;
    int         slow_cnt = 0;
    int         n;
    int         lat;

    always #5 sys_clk = ~sys_clk;

    // The slow clock is derived in cycles so its edges land on rising core edges.
    always @(posedge sys_clk) begin
        slow_cnt <= (slow_cnt == HALF - 1) ? 0 : slow_cnt + 1;
        if (slow_cnt == HALF - 1) begin
            slow_clk <= ~slow_clk;
        end
    end

    swsm_top dut (.sys_clk(sys_clk), .rstn(rstn), .clk_en(clk_en), .slow_clk(slow_clk),
        .sleep_req(sleep_req), .irq_pending(irq_pending), .halt_acknowledge(halt_acknowledge),
        .extended_io_bank_select(bank), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
        .io_wdata(io_wdata), .lvd_cmp_raw(lvd_raw), .por_cmp_raw(por_raw), .io_rdata(io_rdata),
        .halt_request(halt_request), .power_down_strobe(strobe), .monitor_enable(mon_en),
        .por_reset_req(por_req), .flash_enable(flash_en), .monitor_duty_ratio(duty),
        .por_level_select(por_lvl), .lvd_trip_select(trip), .supply_low_flag(low_flag),
        .precise_supply_flag(prec_flag));

    swsm_cpu_model cpu (.sys_clk(sys_clk), .rstn(rstn), .halt_request(halt_request),
        .halt_acknowledge(halt_acknowledge));

    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(input logic b, input logic [8:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        bank <= b;
        io_addr <= a;
        io_wdata <= d;
        io_wr <= 1'b1;
        @(posedge sys_clk);
        io_wr <= 1'b0;
    endtask

    task automatic rd(input logic b, input logic [8:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        bank <= b;
        io_addr <= a;
        io_rd <= 1'b1;
        @(posedge sys_clk);
        io_rd <= 1'b0;
        // Read data stands from the edge that took the read; take it one edge on.
        @(posedge sys_clk);
        d = io_rdata;
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        repeat (60000) @(posedge sys_clk);
        err_count++;
        end_sim();
    end

    initial begin
        // Rows: bank of the write, address, write data, value read back in bank two.
        rows = '{{1'b1, 9'h1e3, 8'hff, 8'h37}, {1'b0, 9'h1e3, 8'h00, 8'h37},
                 {1'b1, 9'h1eb, 8'hff, 8'hc0}, {1'b1, 9'h1e4, 8'hff, 8'h00},
                 {1'b1, 9'h1e5, 8'hff, 8'h00}, {1'b1, 9'h1e3, 8'h12, 8'h12}};
        repeat (16) @(posedge sys_clk);
        rstn <= 1'b1;
        rd(1'b1, 9'h1e3, rv);
        chk("ctrl after reset", rv, 8'h00);
        for (int i = 0; i < 6; i++) begin
            wr(rows[i][25], rows[i][24:16], rows[i][15:8]);
            rd(1'b1, rows[i][24:16], rv);
            chk("register row", rv, rows[i][7:0]);
        end
        chk("fields", {duty, por_lvl, 1'b0, trip}, 8'hd2);
        rd(1'b0, 9'h1e3, rv);
        chk("first bank read", rv, 8'h00);
        lvd_raw <= 1'b1;
        por_raw <= 1'b1;
        rd(1'b1, 9'h1e4, rv);
        chk("status", rv, 8'h03);
        chk("por reset", {7'h00, por_req}, 8'h01);
        chk("flash low flag", {7'h00, flash_en}, 8'h00);
        wr(1'b1, 9'h1e3, 8'h34);
        rd(1'b1, 9'h1e4, rv);
        chk("no reset level", {6'h00, por_req, rv[0]}, 8'h01);
        lvd_raw <= 1'b0;
        repeat (2) @(posedge sys_clk);
        chk("flash reserved trip", {7'h00, flash_en}, 8'h00);
        wr(1'b1, 9'h1e3, 8'h03);
        @(negedge sys_clk);
        chk("flash valid trip", {7'h00, flash_en}, 8'h01);
        // Sleep entry, then a long quiet spell with no interrupt pending.
        @(posedge sys_clk);
        sleep_req <= 1'b1;
        n = 0;
        while (strobe !== 1'b1 && n < 20) begin
            @(posedge sys_clk);
            n++;
        end
        sleep_req <= 1'b0;
        chk("halt in sleep", {6'h00, halt_acknowledge, strobe}, 8'h03);
        repeat (4 * HALF) @(posedge sys_clk);
        chk("stays asleep", {6'h00, halt_request, strobe}, 8'h03);
        // Duty 1/8: the third slow window of the sleep is an off window.
        chk("monitor off asleep", {7'h00, mon_en}, 8'h00);
        // A comparator that trips in sleep must stay hidden until the wake sample.
        irq_pending <= 1'b1;
        lvd_raw <= 1'b1;
        n = 0;
        while (strobe !== 1'b0 && n < 8000) begin
            @(posedge sys_clk);
            n++;
        end
        lat = n;
        chk("strobe released", {6'h00, slow_clk, n > HALF && n <= 3 * HALF + 4}, 8'h03);
        chk("flags frozen", {6'h00, low_flag, prec_flag}, 8'h01);
        chk("monitor awake", {7'h00, mon_en}, 8'h01);
        n = 0;
        while (halt_request !== 1'b0 && n < 8000) begin
            @(posedge sys_clk);
            n++;
        end
        lat = lat + n + 1;
        chk("halt span", {6'h00, slow_clk, n >= 3 * HALF - 3 && n <= 3 * HALF + 3}, 8'h01);
        chk("flags sampled", {6'h00, low_flag, prec_flag}, 8'h03);
        irq_pending <= 1'b0;
        repeat (2) @(negedge sys_clk);
        chk("ack dropped", {7'h00, halt_acknowledge}, 8'h00);
        chk("wake latency", {7'h00, lat >= LAT_MIN && lat <= LAT_MAX}, 8'h01);
        rd(1'b1, 9'h1e4, rv);
        chk("status after wake", rv, 8'h03);
        // A reset in mid-run must clear the registers again.
        @(posedge sys_clk);
        rstn <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rstn <= 1'b1;
        chk("rdata in reset", io_rdata, 8'h00);
        rd(1'b1, 9'h1eb, rv);
        chk("duty after reset", rv, 8'h00);
        rd(1'b1, 9'h1e3, rv);
        chk("ctrl after mid reset", rv, 8'h00);
        end_sim();
    end
endmodule
